//--- gcd_pkg.sv
// package: constants and carrier types for the gripper command decoder
package gcd_pkg;
  localparam logic [31:0] FRAME_START   = 32'hfffefdfc;
  localparam logic [7:0]  FRAME_END     = 8'hfb;
  localparam int          FRAME_BYTES   = 14;
  localparam logic [7:0]  RW_READ       = 8'h00;
  localparam logic [7:0]  RW_WRITE      = 8'h01;
  localparam logic [7:0]  FN_STATUS     = 8'h0f;
  localparam logic [7:0]  FN_PIN        = 8'h10;
  localparam logic [7:0]  FN_CANID      = 8'h12;
  localparam logic [7:0]  FN_VERSION    = 8'h13;
  localparam logic [7:0]  FN_RATE       = 8'h14;
  localparam logic [7:0]  SF_ONE        = 8'h01;
  localparam logic [7:0]  SF_G1_GRIP    = 8'h04;
  localparam logic [7:0]  SF_G2_GRIP    = 8'h08;
  localparam logic [7:0]  SF_PIN_EN     = 8'h09;
  localparam logic [7:0]  SF_G1_F2      = 8'h0a;
  localparam logic [7:0]  SF_G2_F2      = 8'h0b;
  localparam logic [7:0]  WILDCARD_ID   = 8'h00;
  localparam logic [7:0]  CANID_RST     = 8'h01;
  localparam logic [7:0]  CANID_MIN     = 8'h01;
  localparam logic [2:0]  RATE_RST      = 3'h0;
  localparam logic [31:0] RATE_MAX      = 32'h00000005;
  localparam logic [31:0] POS_MAX       = 32'h00000064;
  localparam logic [31:0] FORCE_MIN     = 32'h00000014;
  localparam logic [31:0] FORCE_MAX     = 32'h00000064;
  localparam logic [31:0] PARAM_RST     = 32'h00000000;
  localparam logic [31:0] FORCE_RST     = 32'h00000014;
  localparam logic [1:0]  ST_IDLE       = 2'h0;
  localparam logic [1:0]  ST_ARRIVED    = 2'h2;
  localparam logic [1:0]  ST_CAUGHT     = 2'h3;
  // apb register byte offsets
  localparam logic [7:0]  A_RX          = 8'h00;
  localparam logic [7:0]  A_TX          = 8'h04;
  localparam logic [7:0]  A_STAT        = 8'h08;
  localparam logic [7:0]  A_CFG         = 8'h0c;
  localparam logic [7:0]  A_VER         = 8'h10;
  localparam logic [7:0]  A_MOTION      = 8'h14;
  // one command: header fields plus signed data
  typedef struct packed {
    logic [7:0]  id;
    logic [7:0]  fn;
    logic [7:0]  sub;
    logic [7:0]  rw;
    logic [7:0]  rsv;
    logic [31:0] data;
  } gcd_cmd_t;
  // order: g1p1 g1p2 g1f1 g1f2 g2p1 g2p2 g2f1 g2f2
  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] force_v;
    logic        valid;
  } gcd_move_t;
endpackage

//--- gcd_decoder.sv
// gripper command decoder: framed byte stream in, reply bytes out, apb access
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - frame starts fffefdfc, ends fb
// - read/write byte only zero or one
// - data is little-endian; ignored on reads
// - status query 0f/01 read returns state
// - status codes: 0 idle, 2 arrived, 3 caught
// - pin mode issues command matching pin state; a pin change in the cycle of an accepted 04/08 grip write issues none
// - two pins decode into four states
// - eight parameters stored, range checked, readable
// - sub-function to group parameter mapping
// - position uses force of same index
// - 04/08 write-only grip, data selects position
// - sub-function 09 pin mode enable switch
// - 12/01 reads or sets id 1-255
// - new id applies only after restart; here reset also sets the stored id back to 01, so a written id never goes live
// - id zero is wildcard for id access
// - 13/01 read returns firmware version
// - 14/01 rate index 0-5, after reboot; reset also clears the stored index to 0, so a written rate never goes live
// - rate index decodes to bit rate
module gcd_decoder #(
  parameter logic [31:0] FW_VERSION = 32'h00000001 // arbitrary value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  io_pins,
  output gcd_pkg::gcd_move_t move_r,
  output logic [7:0]       active_id_r,
  output logic [19:0]      active_kbps_r
);
  //////////////////////////////////////////////////////////////////////////
  typedef enum {S_RX, S_EXEC, S_TX} gcd_state_t;
  gcd_state_t          state_r;
  logic [7:0]          buf_r [gcd_pkg::FRAME_BYTES];
  logic [3:0]          cnt_r;
  logic [7:0]          stored_id_r;
  logic [2:0]          rate_r;
  logic                pin_en_r;
  logic [31:0]         par_r [8];
  logic [1:0]          motion_r;
  logic [1:0]          pins_q_r;
  logic                dropped_r;
  logic                tx_valid_r;
  gcd_pkg::gcd_cmd_t   cmd;
  logic                wr_acc, rd_acc, acc, known, ok, wdata_ok, fr_ok;
  logic [2:0]          pidx;
  logic [31:0]         rvalue, wv;

  wire acc_wr   = psel && penable && pwrite;
  wire acc_rd   = psel && penable && !pwrite;
  wire rx_push  = acc_wr && paddr == gcd_pkg::A_RX && state_r == gcd_state_t'(S_RX);
  wire tx_pop   = acc_rd && paddr == gcd_pkg::A_TX && state_r == gcd_state_t'(S_TX);

  //////////////////////////////////////////////////////////////////////////
  // frame fields, data little-endian
  always_comb begin
    cmd.id   = buf_r[4];
    cmd.fn   = buf_r[5];
    cmd.sub  = buf_r[6];
    cmd.rw   = buf_r[7];
    cmd.rsv  = buf_r[8];
    cmd.data = {buf_r[12], buf_r[11], buf_r[10], buf_r[9]};
    wv       = cmd.data;
  end

  always_comb begin
    fr_ok = {buf_r[0], buf_r[1], buf_r[2], buf_r[3]} == gcd_pkg::FRAME_START
            && buf_r[13] == gcd_pkg::FRAME_END;
    rd_acc = cmd.rw == gcd_pkg::RW_READ;
    wr_acc = cmd.rw == gcd_pkg::RW_WRITE;
    pidx   = 3'h0;
    known  = 1'b0;
    wdata_ok = 1'b1;
    rvalue = 32'h00000000;
    case (cmd.sub)
      8'h01: pidx = 3'h0;
      8'h02: pidx = 3'h1;
      8'h03: pidx = 3'h2;
      8'h0a: pidx = 3'h3;
      8'h05: pidx = 3'h4;
      8'h06: pidx = 3'h5;
      8'h07: pidx = 3'h6;
      8'h0b: pidx = 3'h7;
      default: pidx = 3'h0;
    endcase
    case (cmd.fn)
      gcd_pkg::FN_STATUS: begin
        known  = cmd.sub == gcd_pkg::SF_ONE && rd_acc;
        rvalue = {30'h0, motion_r};
      end
      gcd_pkg::FN_PIN: begin
        if (cmd.sub == gcd_pkg::SF_G1_GRIP || cmd.sub == gcd_pkg::SF_G2_GRIP) begin
          known    = wr_acc;
          wdata_ok = wv == 32'h0 || wv == 32'h1;
        end else if (cmd.sub == gcd_pkg::SF_PIN_EN) begin
          known    = 1'b1;
          wdata_ok = wv == 32'h0 || wv == 32'h1;
          rvalue   = {31'h0, pin_en_r};
        end else if (cmd.sub >= 8'h01 && cmd.sub <= gcd_pkg::SF_G2_F2) begin
          known  = 1'b1;
          rvalue = par_r[pidx];
          if (pidx[1]) wdata_ok = !wv[31] && wv >= gcd_pkg::FORCE_MIN
                                  && wv <= gcd_pkg::FORCE_MAX;
          else wdata_ok = !wv[31] && wv <= gcd_pkg::POS_MAX;
        end
      end
      gcd_pkg::FN_CANID: begin
        known    = cmd.sub == gcd_pkg::SF_ONE;
        wdata_ok = wv >= {24'h0, gcd_pkg::CANID_MIN} && wv <= 32'h000000ff;
        rvalue   = {24'h0, stored_id_r};
      end
      gcd_pkg::FN_VERSION: begin
        known  = cmd.sub == gcd_pkg::SF_ONE && rd_acc;
        rvalue = FW_VERSION;
      end
      gcd_pkg::FN_RATE: begin
        known    = cmd.sub == gcd_pkg::SF_ONE;
        wdata_ok = wv <= gcd_pkg::RATE_MAX;
        rvalue   = {29'h0, rate_r};
      end
      default: known = 1'b0;
    endcase
    // id access accepts the wildcard, everything else needs the live id
    ok = fr_ok && (rd_acc || wr_acc) && known && (rd_acc || wdata_ok)
         && (cmd.id == active_id_r
             || (cmd.fn == gcd_pkg::FN_CANID && cmd.id == gcd_pkg::WILDCARD_ID));
    acc = ok;
  end

  //////////////////////////////////////////////////////////////////////////
  // frame buffer: filled over apb, rewritten with the reply in exec
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < gcd_pkg::FRAME_BYTES; i++) buf_r[i] <= 8'h00;
    end else if (rx_push) begin
      buf_r[cnt_r] <= pwdata[7:0];
    end else if (state_r == gcd_state_t'(S_EXEC) && acc && rd_acc) begin
      buf_r[9]  <= rvalue[7:0];
      buf_r[10] <= rvalue[15:8];
      buf_r[11] <= rvalue[23:16];
      buf_r[12] <= rvalue[31:24];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= S_RX;
      cnt_r      <= 4'h0;
      tx_valid_r <= 1'b0;
      dropped_r  <= 1'b0;
    end else begin
      case (state_r)
        S_RX: if (rx_push) begin
          if (cnt_r == 4'(gcd_pkg::FRAME_BYTES - 1)) begin
            cnt_r   <= 4'h0;
            state_r <= S_EXEC;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_EXEC: begin
          dropped_r  <= !acc;
          tx_valid_r <= acc;
          state_r    <= acc ? S_TX : S_RX;
        end
        S_TX: if (tx_pop) begin
          if (cnt_r == 4'(gcd_pkg::FRAME_BYTES - 1)) begin
            cnt_r      <= 4'h0;
            tx_valid_r <= 1'b0;
            state_r    <= S_RX;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: state_r <= S_RX;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings written by accepted write frames
  wire do_wr = state_r == gcd_state_t'(S_EXEC) && acc && wr_acc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // slots 2,3,6,7 are forces; reset picks by slot, never by live decode
      for (int i = 0; i < 8; i++) par_r[i] <= i[1] ? gcd_pkg::FORCE_RST : gcd_pkg::PARAM_RST;
      pin_en_r    <= 1'b0;
      stored_id_r <= gcd_pkg::CANID_RST;
      rate_r      <= gcd_pkg::RATE_RST;
    end else if (do_wr) begin
      if (cmd.fn == gcd_pkg::FN_PIN && cmd.sub == gcd_pkg::SF_PIN_EN)
        pin_en_r <= wv[0];
      else if (cmd.fn == gcd_pkg::FN_PIN && cmd.sub != gcd_pkg::SF_G1_GRIP
               && cmd.sub != gcd_pkg::SF_G2_GRIP)
        par_r[pidx] <= wv;
      if (cmd.fn == gcd_pkg::FN_CANID) stored_id_r <= wv[7:0];
      if (cmd.fn == gcd_pkg::FN_RATE) rate_r <= wv[2:0];
    end
  end

  // live id and rate load only at reset release (restart)
  logic boot_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r        <= 1'b1;
      active_id_r   <= gcd_pkg::CANID_RST;
      active_kbps_r <= 20'h0;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        active_id_r <= stored_id_r;
        case (rate_r)
          3'h0: active_kbps_r <= 20'h001f4;
          3'h1: active_kbps_r <= 20'h00190;
          3'h2: active_kbps_r <= 20'h000fa;
          3'h3: active_kbps_r <= 20'h000c8;
          3'h4: active_kbps_r <= 20'h0007d;
          default: active_kbps_r <= 20'h00064;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // move requests: grip commands and pin-mode pin changes
  // pins: bit1 picks group, bit0 picks position (four states)
  logic [2:0] mv_base;
  logic       mv_go;
  always_comb begin
    mv_go   = 1'b0;
    mv_base = 3'h0;
    if (do_wr && cmd.fn == gcd_pkg::FN_PIN
        && (cmd.sub == gcd_pkg::SF_G1_GRIP || cmd.sub == gcd_pkg::SF_G2_GRIP)) begin
      mv_go   = 1'b1;
      mv_base = {cmd.sub == gcd_pkg::SF_G2_GRIP, 1'b0, wv[0]};
    end else if (pin_en_r && io_pins != pins_q_r) begin
      mv_go   = 1'b1;
      mv_base = {io_pins[1], 1'b0, io_pins[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q_r <= 2'h0;
      move_r   <= '0;
    end else begin
      pins_q_r     <= io_pins;
      move_r.valid <= mv_go;
      if (mv_go) begin
        move_r.pos     <= par_r[mv_base];
        move_r.force_v <= par_r[mv_base | 3'h2];
      end
    end
  end

  // motion state reported by the actuator over apb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) motion_r <= gcd_pkg::ST_IDLE;
    else if (acc_wr && paddr == gcd_pkg::A_MOTION) motion_r <= pwdata[1:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped reads zero, error only for addresses above A_MOTION
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > gcd_pkg::A_MOTION;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          gcd_pkg::A_TX:     prdata <= {24'h0, buf_r[cnt_r]};
          gcd_pkg::A_STAT:   prdata <= {24'h0, 2'(state_r), dropped_r, tx_valid_r, cnt_r};
          gcd_pkg::A_CFG:    prdata <= {8'h0, 5'h0, rate_r, stored_id_r, 7'h0, pin_en_r};
          gcd_pkg::A_VER:    prdata <= FW_VERSION;
          gcd_pkg::A_MOTION: prdata <= {30'h0, motion_r};
          default:           prdata <= 32'h0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  canid_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    stored_id_r != 8'h00) else $error("stored id left range");
  rate_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    rate_r <= 3'h5) else $error("rate index left range");
  bad_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == S_EXEC && !fr_ok |=> state_r == S_RX) else $error("bad frame answered");
  reply_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == S_EXEC && acc |=> tx_valid_r && state_r == S_TX) else $error("no reply");
  id_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !boot_r |=> $stable(active_id_r)) else $error("live id changed without restart");
  pin_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    do_wr && cmd.fn == 8'h10 && cmd.sub == 8'h09 |=> pin_en_r == $past(wv[0]))
    else $error("pin enable not stored");
  move_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    mv_go |=> move_r.valid && move_r.force_v == $past(par_r[mv_base | 3'h2]))
    else $error("position not paired with its force");
  status_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == S_EXEC && acc && cmd.fn == 8'h0f |=> buf_r[9] == {6'h0, $past(motion_r)})
    else $error("status not returned");
endmodule

//--- gcd_ctrl_model.sv
// controller-side model: presents the two level pins to the decoder
`timescale 1ns/1ps
module gcd_ctrl_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] pin_req,
  output logic      [1:0] io_pins
);
  // pins move only just after an edge and then hold as steady levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pins <= 2'h0;
    end else begin
      io_pins <= pin_req;
    end
  end
endmodule

//--- gripper_command_decoder_tb_top.sv
// testbench: frames over apb, checks replies, moves and stored settings
`timescale 1ns/1ps
module gripper_command_decoder_tb_top;
  localparam logic [31:0] VER = 32'h00000102; // arbitrary version value
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [1:0]         pin_req = 2'h0;
  logic [1:0]         io_pins;
  gcd_pkg::gcd_move_t move_r;
  logic [7:0]         active_id_r;
  logic [19:0]        active_kbps_r;
  int                 error_cnt = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  int                 mv_n = 0;
  logic [31:0]        mv_pos;
  logic [31:0]        mv_f;
  logic [31:0]        prm [8];
  logic [7:0]         subs [8] = '{8'h01, 8'h02, 8'h03, 8'h0a, 8'h05, 8'h06, 8'h07, 8'h0b};
  logic [31:0]        q;
  logic [31:0]        st;
  logic               e;
  logic [111:0]       rep;
  logic [111:0]       f;

  gcd_decoder #(.FW_VERSION(VER)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_pins(io_pins), .move_r(move_r),
    .active_id_r(active_id_r), .active_kbps_r(active_kbps_r));
  gcd_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .pin_req(pin_req), .io_pins(io_pins));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (move_r.valid === 1'b1) begin
      mv_pos = move_r.pos;
      mv_f = move_r.force_v;
      mv_n++;
    end
    // a hung handshake lands here and fails the run
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_val(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_frame(input string n, input logic [111:0] x, input logic [111:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  // one setup cycle, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the cycle ceiling ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [111:0] mk(input gcd_pkg::gcd_cmd_t c);
    mk = {gcd_pkg::FRAME_START, c.id, c.fn, c.sub, c.rw, c.rsv, c.data[7:0], c.data[15:8],
          c.data[23:16], c.data[31:24], gcd_pkg::FRAME_END};
  endfunction
  function automatic gcd_pkg::gcd_cmd_t cm(input logic [7:0] id, fn, sb, rw, input logic [31:0] d);
    cm = {id, fn, sb, rw, 8'h00, d};
  endfunction
  // bytes in wire order, then the whole reply is drained when one is offered
  task automatic send(input logic [111:0] fr);
    for (int i = 0; i < 14; i++) apb(1'b1, gcd_pkg::A_RX, {24'h0, fr[111-8*i -: 8]});
    apb(1'b0, gcd_pkg::A_STAT, 32'h0);
    st = q;
    rep = '0;
    if (st[4] === 1'b1) begin
      for (int i = 0; i < 14; i++) begin
        apb(1'b0, gcd_pkg::A_TX, 32'h0);
        rep[111-8*i -: 8] = q[7:0];
      end
    end
  endtask
  task automatic xact(input string n, input gcd_pkg::gcd_cmd_t c, input logic [31:0] de,
                      input logic ok);
    send(mk(c));
    chk_val(n, {30'h0, !ok, ok}, {30'h0, st[5], st[4]});
    c.data = de;
    if (ok) chk_frame(n, mk(c), rep);
  endtask
  task automatic chk_move(input int g, input int p, input int n0);
    for (int k = 0; k < 20 && mv_n == n0; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk_val("move count", n0 + 1, mv_n);
    chk_val("move pos", prm[g*4+p], mv_pos);
    chk_val("move force", prm[g*4+2+p], mv_f);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h469a004e));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // live rate loads at the first edge after release
    repeat (2) @(posedge pclk);
    chk_val("kbps", 500, {12'h0, active_kbps_r});
    xact("version", cm(1, gcd_pkg::FN_VERSION, 1, 0, 0), VER, 1);
    foreach (prm[i]) begin
      prm[i] = (i % 4 >= 2) ? $urandom_range(100, 20) : $urandom_range(100, 0);
      if (i == 0) prm[i] = 32'h0;
      if (i == 2) prm[i] = gcd_pkg::FORCE_MAX;
      xact("param wr", cm(1, 8'h10, subs[i], 1, prm[i]), prm[i], 1);
    end
    xact("force low", cm(1, 8'h10, 8'h03, 1, 32'h13), 0, 0);
    xact("pos high", cm(1, 8'h10, 8'h01, 1, 32'h65), 0, 0);
    foreach (prm[i]) xact("param rd", cm(1, 8'h10, subs[i], 0, $urandom), prm[i], 1);
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 2; p++) begin
        int n0;
        n0 = mv_n;
        xact("grip", cm(1, 8'h10, g ? 8'h08 : 8'h04, 1, p), p, 1);
        chk_move(g, p, n0);
      end
    end
    xact("pin en", cm(1, 8'h10, 8'h09, 1, 1), 1, 1);
    xact("pin en rd", cm(1, 8'h10, 8'h09, 0, 0), 1, 1);
    foreach (subs[k]) if (k < 4) begin
      int n0;
      logic [1:0] pv;
      pv = (k == 0) ? 2'h1 : (k == 1) ? 2'h3 : (k == 2) ? 2'h2 : 2'h0;
      n0 = mv_n;
      pin_req <= pv;
      chk_move(pv[1], pv[0], n0);
    end
    foreach (subs[k]) if (k < 3) begin
      logic [1:0] code;
      code = (k == 0) ? gcd_pkg::ST_IDLE : (k == 1) ? gcd_pkg::ST_ARRIVED : gcd_pkg::ST_CAUGHT;
      apb(1'b1, gcd_pkg::A_MOTION, {30'h0, code});
      xact("status", cm(1, 8'h0f, 1, 0, $urandom), {30'h0, code}, 1);
    end
    xact("id set", cm(0, 8'h12, 1, 1, 2), 2, 1);
    xact("id zero", cm(0, 8'h12, 1, 1, 0), 0, 0);
    xact("id rd", cm(0, 8'h12, 1, 0, 0), 2, 1);
    chk_val("live id", 1, {24'h0, active_id_r});
    for (int r = 0; r < 7; r++) xact("rate", cm(1, 8'h14, 1, 1, r), r, r < 6);
    xact("rate rd", cm(1, 8'h14, 1, 0, 0), 5, 1);
    chk_val("live kbps", 500, {12'h0, active_kbps_r});
    f = mk(cm(1, 8'h13, 1, 0, 0));
    send(f ^ {8'h01, 104'h0});
    chk_val("bad start", 2, {30'h0, st[5], st[4]});
    send(f ^ 112'h1);
    chk_val("bad end", 2, {30'h0, st[5], st[4]});
    xact("bad rw", cm(1, 8'h13, 1, 2, 0), 0, 0);
    xact("bad fn", cm(1, 8'h11, 1, 0, 0), 0, 0);
    apb(1'b0, 8'h18, 32'h0);
    chk_val("unmapped", 32'h1, {31'h0, e});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_val("rst id", 1, {24'h0, active_id_r});
    chk_val("rst kbps", 500, {12'h0, active_kbps_r});
    end_of_test();
  end
endmodule
